// ===== logic/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Time base and setup
    input wire logic tick_i,
    input wire logic [3:0] on_code_i,
    input wire logic [2:0] period_code_i,
    input wire logic [hss_pwm_pkg::CNT_W-1:0] sample_ticks_i,
    // Switch drive and wake sample strobe
    output logic drive_o,
    output logic drive_en_o,
    output logic sample_o
);

    logic [hss_pwm_pkg::CNT_W-1:0] count;
    logic [hss_pwm_pkg::CNT_W-1:0] period;
    logic [hss_pwm_pkg::CNT_W-1:0] width;
    logic next_drive;

    assign period = hss_pwm_pkg::period_ticks(period_code_i);
    assign width = hss_pwm_pkg::on_ticks(on_code_i);

    // Free-running period counter in ticks
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            count <= '0;
        else if (tick_i)
        begin
            if (count >= period - 1'b1)
                count <= '0;
            else
                count <= count + 1'b1;
        end
    end

    // On from period start until the width has elapsed
    always_comb
    begin
        if (on_code_i == hss_pwm_pkg::ON_CODE_FULL)
            next_drive = 1'b1;
        else if (on_code_i == hss_pwm_pkg::ON_CODE_OFF)
            next_drive = 1'b0;
        else
            next_drive = count < width;
    end

    // Registered drive, enable and sample strobe
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_o <= 1'b0;
            drive_en_o <= 1'b0;
            sample_o <= 1'b0;
        end
        else
        begin
            drive_o <= next_drive;
            drive_en_o <= on_code_i != hss_pwm_pkg::ON_CODE_OFF;
            sample_o <= tick_i && next_drive && count == sample_ticks_i;
        end
    end

    period_wrap_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick_i |=> count < $past(period))
        else $error("timer count passed its period");

    on_width_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        on_code_i != hss_pwm_pkg::ON_CODE_OFF && on_code_i != hss_pwm_pkg::ON_CODE_FULL
        |=> drive_o == ($past(count) < $past(width)))
        else $error("timer drive disagrees with on width");

    off_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        on_code_i == hss_pwm_pkg::ON_CODE_OFF |=> !drive_en_o && !drive_o)
        else $error("timer drives with off code");

    full_code_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        on_code_i == hss_pwm_pkg::ON_CODE_FULL [*2] |-> drive_o && drive_en_o)
        else $error("timer not fully on");

endmodule

// ===== logic/hss_pwm_pkg.sv
package hss_pwm_pkg;

    // Clock and derived time base
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TICK_NS = 5000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 7;
    localparam int CNT_W = 19;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATE = 8'h22;
    localparam logic [7:0] IDX_DUTY_HIGH = 8'h23;
    localparam logic [7:0] IDX_DUTY_LOW = 8'h24;
    localparam logic [7:0] IDX_TIMER_ONE = 8'h25;
    localparam logic [7:0] IDX_TIMER_TWO = 8'h26;
    localparam logic [7:0] IDX_STATUS = 8'h2C;
    localparam logic [7:0] IDX_WAKE_CFG = 8'h2D;
    localparam int ADDR_W = 10;

    // Field positions
    localparam int RATE_BIT = 7;
    localparam int ON_LSB = 4;
    localparam int PERIOD_LSB = 0;
    localparam int ST_PWM = 0;
    localparam int ST_T1 = 1;
    localparam int ST_T2 = 2;
    localparam int ST_WAKE_LVL = 3;
    localparam int ST_WAKE_CHG = 4;

    // Reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_HIGH = 2'h0;

    // Second channel: 10-bit duty, 1024 steps per period
    localparam int DUTY_W = 10;
    localparam logic [9:0] DUTY_FULL = 10'h3FF;
    localparam int unsigned PWM_STEPS = 1024;
    localparam int unsigned PWM_SLOW_HZ = 200;
    localparam int unsigned PWM_FAST_HZ = 400;
    localparam int unsigned PWM_STEP_SLOW = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
    localparam int unsigned PWM_STEP_FAST = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
    localparam int PRE_W = 7;

    // On-width codes
    localparam logic [3:0] ON_CODE_OFF = 4'h0;
    localparam logic [3:0] ON_CODE_FULL = 4'hF;
    localparam int unsigned ON_TIME_US [16] = '{0, 100, 300, 500, 1000, 10000, 20000,
        30000, 40000, 50000, 60000, 80000, 100000, 150000, 200000, 0};
    localparam int unsigned PERIOD_MS [8] = '{10, 20, 50, 100, 200, 500, 1000, 2000};

    // Cyclic wake sample times
    localparam int unsigned WAKE_SHORT_US = 65;
    localparam int unsigned WAKE_LONG_US = 250;

    function automatic logic [CNT_W-1:0] on_ticks(input logic [3:0] code);
        on_ticks = CNT_W'(ON_TIME_US[code] * 1000 / TICK_NS);
    endfunction

    function automatic logic [CNT_W-1:0] period_ticks(input logic [2:0] code);
        period_ticks = CNT_W'(PERIOD_MS[code] * 1000000 / TICK_NS);
    endfunction

    function automatic logic [CNT_W-1:0] us_ticks(input int unsigned us);
        us_ticks = CNT_W'((us * 1000 + TICK_NS - 1) / TICK_NS);
    endfunction

endpackage

// ===== logic/hss_pwm_timer.sv
// Summary of operation
// - Low duty byte forms duty bits seven-zero
// - Duty zero keeps switch off whole period
// - Duty all ones keeps switch fully on
// - Each duty step adds one period step
// - Timer one on code; zero off, fifteen on
// - Timer two uses same on codes
// - Codes one to fourteen map to on-times
// - Timer one period from bits two-zero
// - Period codes ten ms to two seconds
// - Wake sampled inside on window, change flagged
// - Duty top two bits from separate field
// - Rate bit selects 200 or 400 Hz
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module hss_pwm_timer
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [hss_pwm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Wake pin for cyclic sensing
    input wire logic wake_i,
    // High-side switch drive sources and wake change flag
    output logic pwm_drive_o,
    output logic timer_one_drive_o,
    output logic timer_one_drive_en_o,
    output logic timer_two_drive_o,
    output logic timer_two_drive_en_o,
    output logic wake_changed_o
);

    // Software registers
    logic second_channel_rate_select;
    logic [1:0] second_channel_duty_high;
    logic [7:0] second_channel_duty_low;
    logic [3:0] timer_one_on_time;
    logic [2:0] timer_one_repeat;
    logic [3:0] timer_two_on_time;
    logic [2:0] timer_two_repeat;
    logic wake_long_select;
    logic wake_changed;
    logic wake_level;

    // Bus decode
    logic [7:0] index;
    logic aligned;
    logic hit;
    logic wr_en;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic [31:0] next_rdata;

    assign index = paddr_i[hss_pwm_pkg::ADDR_W-1:2];
    assign aligned = paddr_i[1:0] == 2'h0;
    assign wr_lane0 = pstrb_i[0];
    assign wbyte = pwdata_i[7:0];

    // Address match for every mapped register
    always_comb
    begin
        unique case (index)
            hss_pwm_pkg::IDX_RATE,
            hss_pwm_pkg::IDX_DUTY_HIGH,
            hss_pwm_pkg::IDX_DUTY_LOW,
            hss_pwm_pkg::IDX_TIMER_ONE,
            hss_pwm_pkg::IDX_TIMER_TWO,
            hss_pwm_pkg::IDX_STATUS,
            hss_pwm_pkg::IDX_WAKE_CFG: hit = aligned;
            default: hit = 1'b0;
        endcase
    end

    // Zero wait states; unmapped access answers with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !hit;
    assign wr_en = psel_i && penable_i && pwrite_i && hit && wr_lane0;

    // Rate select register
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            second_channel_rate_select <= 1'b0;
        else if (wr_en && index == hss_pwm_pkg::IDX_RATE)
            second_channel_rate_select <= wbyte[hss_pwm_pkg::RATE_BIT];
    end

    // Duty registers, high field and low byte
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            second_channel_duty_high <= hss_pwm_pkg::RESET_HIGH;
            second_channel_duty_low <= hss_pwm_pkg::RESET_BYTE;
        end
        else if (wr_en)
        begin
            if (index == hss_pwm_pkg::IDX_DUTY_HIGH)
                second_channel_duty_high <= wbyte[1:0];
            if (index == hss_pwm_pkg::IDX_DUTY_LOW)
                second_channel_duty_low <= wbyte;
        end
    end

    // Timer configuration registers
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            timer_one_on_time <= hss_pwm_pkg::ON_CODE_OFF;
            timer_one_repeat <= 3'h0;
            timer_two_on_time <= hss_pwm_pkg::ON_CODE_OFF;
            timer_two_repeat <= 3'h0;
            wake_long_select <= 1'b0;
        end
        else if (wr_en)
        begin
            if (index == hss_pwm_pkg::IDX_TIMER_ONE)
            begin
                timer_one_on_time <= wbyte[hss_pwm_pkg::ON_LSB +: 4];
                timer_one_repeat <= wbyte[hss_pwm_pkg::PERIOD_LSB +: 3];
            end
            if (index == hss_pwm_pkg::IDX_TIMER_TWO)
            begin
                timer_two_on_time <= wbyte[hss_pwm_pkg::ON_LSB +: 4];
                timer_two_repeat <= wbyte[hss_pwm_pkg::PERIOD_LSB +: 3];
            end
            if (index == hss_pwm_pkg::IDX_WAKE_CFG)
                wake_long_select <= wbyte[0];
        end
    end

    // Read data captured in the setup phase
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        unique case (index)
            hss_pwm_pkg::IDX_RATE:
                next_rdata[hss_pwm_pkg::RATE_BIT] = second_channel_rate_select;
            hss_pwm_pkg::IDX_DUTY_HIGH: next_rdata[1:0] = second_channel_duty_high;
            hss_pwm_pkg::IDX_DUTY_LOW: next_rdata[7:0] = second_channel_duty_low;
            hss_pwm_pkg::IDX_TIMER_ONE: next_rdata[7:0] = {timer_one_on_time, 1'b0,
                timer_one_repeat};
            hss_pwm_pkg::IDX_TIMER_TWO: next_rdata[7:0] = {timer_two_on_time, 1'b0,
                timer_two_repeat};
            hss_pwm_pkg::IDX_STATUS:
            begin
                next_rdata[hss_pwm_pkg::ST_PWM] = pwm_drive_o;
                next_rdata[hss_pwm_pkg::ST_T1] = timer_one_drive_o;
                next_rdata[hss_pwm_pkg::ST_T2] = timer_two_drive_o;
                next_rdata[hss_pwm_pkg::ST_WAKE_LVL] = wake_level;
                next_rdata[hss_pwm_pkg::ST_WAKE_CHG] = wake_changed;
            end
            hss_pwm_pkg::IDX_WAKE_CFG: next_rdata[0] = wake_long_select;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            prdata_o <= 32'h0000_0000;
        else if (psel_i && !penable_i && !pwrite_i)
            prdata_o <= aligned ? next_rdata : 32'h0000_0000;
    end

    // Second channel: prescaler and 10-bit step counter
    logic [hss_pwm_pkg::PRE_W-1:0] pre_count;
    logic [hss_pwm_pkg::PRE_W-1:0] pre_limit;
    logic step_en;
    logic [hss_pwm_pkg::DUTY_W-1:0] pwm_step;
    logic [hss_pwm_pkg::DUTY_W-1:0] active_duty;

    assign pre_limit = second_channel_rate_select
        ? hss_pwm_pkg::PRE_W'(hss_pwm_pkg::PWM_STEP_FAST - 1)
        : hss_pwm_pkg::PRE_W'(hss_pwm_pkg::PWM_STEP_SLOW - 1);
    assign step_en = pre_count >= pre_limit;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pre_count <= '0;
        else if (step_en)
            pre_count <= '0;
        else
            pre_count <= pre_count + 1'b1;
    end

    // Step counter; new duty is taken at each period start
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pwm_step <= '0;
            active_duty <= '0;
        end
        else if (step_en)
        begin
            pwm_step <= pwm_step + 1'b1;
            if (pwm_step == hss_pwm_pkg::DUTY_FULL)
                active_duty <= {second_channel_duty_high, second_channel_duty_low};
        end
    end

    // Switch on while step is below duty; full code holds it on
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pwm_drive_o <= 1'b0;
        else if (active_duty == hss_pwm_pkg::DUTY_FULL)
            pwm_drive_o <= 1'b1;
        else
            pwm_drive_o <= pwm_step < active_duty;
    end

    // Common tick for both timers
    logic [hss_pwm_pkg::TICK_W-1:0] tick_count;
    logic tick;

    assign tick = tick_count == hss_pwm_pkg::TICK_W'(hss_pwm_pkg::TICK_CYCLES - 1);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            tick_count <= '0;
        else if (tick)
            tick_count <= '0;
        else
            tick_count <= tick_count + 1'b1;
    end

    // Wake sample point within the on window
    logic [hss_pwm_pkg::CNT_W-1:0] sample_ticks;
    logic t1_sample;

    assign sample_ticks = wake_long_select ? hss_pwm_pkg::us_ticks(hss_pwm_pkg::WAKE_LONG_US)
        : hss_pwm_pkg::us_ticks(hss_pwm_pkg::WAKE_SHORT_US);

    cycle_timer timer_one
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .on_code_i(timer_one_on_time),
        .period_code_i(timer_one_repeat),
        .sample_ticks_i(sample_ticks),
        .drive_o(timer_one_drive_o),
        .drive_en_o(timer_one_drive_en_o),
        .sample_o(t1_sample)
    );

    cycle_timer timer_two
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .tick_i(tick),
        .on_code_i(timer_two_on_time),
        .period_code_i(timer_two_repeat),
        .sample_ticks_i(sample_ticks),
        .drive_o(timer_two_drive_o),
        .drive_en_o(timer_two_drive_en_o),
        .sample_o()
    );

    // Wake pin synchroniser
    logic wake_meta;
    logic wake_sync;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end
        else
        begin
            wake_meta <= wake_i;
            wake_sync <= wake_meta;
        end
    end

    // Cyclic sensing: compare each sample with the last
    logic wake_clear;
    logic wake_event;

    assign wake_clear = wr_en && index == hss_pwm_pkg::IDX_STATUS
        && wbyte[hss_pwm_pkg::ST_WAKE_CHG];
    assign wake_event = t1_sample && wake_sync != wake_level;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wake_level <= 1'b0;
            wake_changed <= 1'b0;
        end
        else
        begin
            if (t1_sample)
                wake_level <= wake_sync;
            if (wake_event)
                wake_changed <= 1'b1;
            else if (wake_clear)
                wake_changed <= 1'b0;
        end
    end

    assign wake_changed_o = wake_changed;

    duty_join_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        step_en && pwm_step == hss_pwm_pkg::DUTY_FULL
        |=> active_duty == {$past(second_channel_duty_high), $past(second_channel_duty_low)})
        else $error("duty not joined from both fields");

    full_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        active_duty == 10'h000 [*2] |-> !pwm_drive_o)
        else $error("switch on with zero duty");

    full_on_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        active_duty == hss_pwm_pkg::DUTY_FULL |=> pwm_drive_o)
        else $error("switch off with full duty");

    duty_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        active_duty != hss_pwm_pkg::DUTY_FULL
        |=> pwm_drive_o == ($past(pwm_step) < $past(active_duty)))
        else $error("drive does not follow duty compare");

    rate_step_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        step_en && second_channel_rate_select
        |=> !step_en [*8] ##53 (step_en || !second_channel_rate_select))
        else $error("fast step spacing wrong");

    wake_flag_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wake_event |=> wake_changed && wake_level == $past(wake_sync))
        else $error("wake change not flagged");

endmodule

// ===== testbench/high_side_switch_pwm_timer_tb_top.sv
`timescale 1ns/1ps
module high_side_switch_pwm_timer_tb_top;
    // Bench signals
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [9:0] paddr_i = 10'h000;
    logic [31:0] pwdata_i = 32'h00000000;
    logic [3:0] pstrb_i = 4'hF;
    logic sensor = 1'b0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, wake_i, pwm_drive_o, wake_changed_o;
    logic t1_drv, t1_en, t2_drv, t2_en;
    logic [31:0] rd;
    logic rerr;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    // Clock at 25 MHz
    initial
    begin
        forever #20 clk_i = ~clk_i;
    end

    // Block under test and its switch load
    hss_pwm_timer dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .wake_i(wake_i),
        .pwm_drive_o(pwm_drive_o), .timer_one_drive_o(t1_drv),
        .timer_one_drive_en_o(t1_en), .timer_two_drive_o(t2_drv),
        .timer_two_drive_en_o(t2_en), .wake_changed_o(wake_changed_o));
    hss_load_model load_u (.drive_i(t1_drv), .drive_en_i(t1_en), .sensor_i(sensor),
        .wake_o(wake_i));

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 110000)
        begin
            err_count++;
            give_verdict();
        end
    end

    task automatic check_val(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_near(input string what, input int exp, input int got, input int tol);
        comparisons++;
        if (got > exp + tol || got < exp - tol)
        begin
            err_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One APB transfer; result lands in rd and rerr
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        // Wait states end only by pready; the hang guard bounds the wait
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        rd = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic do_reset;
        resetn_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
    endtask

    // Reset values, access kinds, strobe and unmapped address
    task automatic test_regs;
        logic [7:0] idx [6] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2D};
        logic [7:0] msk [6] = '{8'h80, 8'h03, 8'hFF, 8'hF7, 8'hF7, 8'h01};
        do_reset();
        check_val("outputs at reset", 32'h0, {pwm_drive_o, t1_drv, t1_en, t2_drv, t2_en});
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b0, idx[i], 32'h0);
            check_val("reset value", 32'h0, rd);
            apb(1'b1, idx[i], 32'hFFFFFFFF);
            apb(1'b0, idx[i], 32'h0);
            check_val("readback", {24'h0, msk[i]}, rd);
        end
        pstrb_i <= 4'h0;
        apb(1'b1, 8'h24, 32'h0);
        pstrb_i <= 4'hF;
        apb(1'b0, 8'h24, 32'h0);
        check_val("no lane write", 32'hFF, rd);
        apb(1'b0, 8'h27, 32'h0);
        check_val("unmapped error", 32'h1, {31'h0, rerr});
        check_val("unmapped data", 32'h0, rd);
        $display("test_regs done");
    endtask

    // On-times of both timers, wake sampling, end codes
    task automatic test_timers;
        logic [7:0] c1 [2] = '{8'h20, 8'h30};
        logic [7:0] c2 [2] = '{8'h10, 8'h30};
        int u1 [2] = '{300, 500};
        int u2 [2] = '{100, 500};
        int h1, h2;
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            sensor <= (i == 0);
            apb(1'b1, 8'h25, {24'h0, c1[i]});
            apb(1'b1, 8'h26, {24'h0, c2[i]});
            h1 = 0;
            h2 = 0;
            // Window just past the longer on-time keeps the run short
            for (int n = 1; n <= u1[i] * 25 + 300; n++)
            begin
                @(posedge clk_i);
                if (t1_drv === 1'b1)
                    h1 = n;
                if (t2_drv === 1'b1)
                    h2 = n;
            end
            check_near("timer one on", u1[i] * 25, h1, 260);
            check_near("timer two on", u2[i] * 25, h2, 260);
            check_val("enables", 32'h3, {t1_en, t2_en});
            check_val("wake flag", {31'h0, sensor}, {31'h0, wake_changed_o});
            apb(1'b0, 8'h2C, 32'h0);
            check_val("status", {sensor, sensor, 3'b000}, rd[4:0]);
            apb(1'b1, 8'h2C, 32'h10);
            apb(1'b0, 8'h2C, 32'h0);
            check_val("status cleared", {1'b0, sensor, 3'b000}, rd[4:0]);
        end
        apb(1'b1, 8'h25, 32'hF0);
        apb(1'b1, 8'h26, 32'h00);
        repeat (10) @(posedge clk_i);
        check_val("end codes", 32'hC, {t1_drv, t1_en, t2_drv, t2_en});
        $display("test_timers done");
    endtask

    // Second channel at 400 Hz with a ten-bit duty
    task automatic test_pwm;
        int n, h;
        do_reset();
        apb(1'b1, 8'h22, 32'h80);
        apb(1'b1, 8'h23, 32'h01);
        apb(1'b1, 8'h24, 32'h05);
        n = 0;
        while (pwm_drive_o !== 1'b1 && n < 70000)
        begin
            n++;
            @(posedge clk_i);
        end
        check_val("zero duty period", 32'h1, {31'h0, n >= 60000});
        h = 0;
        while (pwm_drive_o === 1'b1 && h < 70000)
        begin
            h++;
            @(posedge clk_i);
        end
        check_near("pwm high", 261 * 62500 / 1024, h, 130);
        $display("test_pwm done");
    endtask

    // Main sequence
    initial
    begin
        test_regs();
        test_timers();
        test_pwm();
        give_verdict();
    end
endmodule

// ===== testbench/hss_load_model.sv
`timescale 1ns/1ps
module hss_load_model
(
    // Switch drive from the block
    input wire logic drive_i,
    input wire logic drive_en_i,
    // Sensor state chosen by the bench
    input wire logic sensor_i,
    // Wake pin back to the block
    output logic wake_o
);
    // Sensor powered only while the switch conducts; pull-down otherwise
    assign wake_o = (drive_en_i & drive_i) ? sensor_i : 1'b0;
endmodule
